// >>> eeprom_slave.sv
// two-wire serial eeprom slave: bus front end, page buffer, ecc memory
// assumes scl/sda from a bus master; clk is a free-running 25 MHz core
// clock; rstn is synchronous to clk
`include "eeprom_map.svh"
`default_nettype none

module eeprom_slave #(
    parameter int unsigned WR_CYCLES = `T_WR_NS / `CLK_PERIOD_NS
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic chip_select_strap_bit0,
    input  wire logic chip_select_strap_bit1,
    input  wire logic chip_select_strap_bit2,
    input  wire logic write_protect,
    output logic      write_busy
);
    import eeprom_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // storage
    // erased delivery state with matching check bits; set here so that
    // the commit process stays the only writer of both arrays
    logic [7:0]      mem [0:`MEM_BYTES-1] =
                         '{default: `ERASED_BYTE};
    logic [5:0]      ecc [0:`ECC_GROUPS-1] =
                         '{default: `ERASED_ECC};
    logic [7:0]      page_buf [0:63];
    logic [63:0]     buf_mask_reg;

    // link side (scl domain)
    link_state_e     lstate_reg;
    logic [3:0]      cnt_reg;
    logic [7:0]      sh_reg;
    logic [7:0]      tx_reg;
    logic            oe_reg;
    logic            rw_reg;
    logic            wp_blk_reg;
    logic            wr_pend_reg;
    logic            start_mark_reg;
    logic            sda_pos_reg;
    mem_addr_t       ptr_reg;
    logic            rr_meta_reg;
    logic            rr_sync_reg;
    logic            bz_meta_reg;
    logic            bz_sync_reg;
    logic [3:0]      pin_meta_reg;
    logic [3:0]      pin_sync_reg;
    logic            stop_flag_reg;

    // core side (clk domain)
    core_state_e     cstate_reg;
    logic [16:0]     wait_reg;
    logic [5:0]      idx_reg;
    logic            rst_req_reg;
    logic            stop_meta_reg;
    logic            stop_sync_reg;
    logic            stop_prev_reg;
    logic            wrp_meta_reg;
    logic            wrp_sync_reg;
    logic            busy_reg;

    logic            link_rst;
    logic            start_det;
    logic            byte_end;
    logic            ack_end;
    logic            addr_hit;
    logic            wr_accept;
    logic            stop_rise;
    logic [7:0]      rx_byte;
    logic [7:0]      rd_data;
    logic [31:0]     rd_word;
    logic [31:0]     new_word;
    logic [12:0]     rd_group;
    logic [12:0]     wr_group;

    ////////////////////////////////////////////////////////////////////
    // hamming code over 32 data bits: data sit at non power-of-two
    // positions 3..38, the check word is the xor of set positions
    function automatic logic [5:0] hcode(input logic [31:0] w);
        logic [5:0] c;
        logic [5:0] p;
        c = 6'h00;
        p = 6'h02;
        for (int i = 0; i < 32; i++) begin
            p = p + 6'h01;
            if ((p & (p - 6'h01)) == 6'h00) begin
                p = p + 6'h01;
            end
            if (w[i]) begin
                c = c ^ p;
            end
        end
        return c;
    endfunction

    // single-bit correction: flip the data bit whose position is the
    // syndrome; a flipped check bit alone leaves the data as is
    function automatic logic [31:0] hfix(input logic [31:0] w,
                                         input logic [5:0]  c);
        logic [5:0]  s;
        logic [5:0]  p;
        logic [31:0] r;
        s = hcode(w) ^ c;
        p = 6'h02;
        r = w;
        for (int i = 0; i < 32; i++) begin
            p = p + 6'h01;
            if ((p & (p - 6'h01)) == 6'h00) begin
                p = p + 6'h01;
            end
            if (s == p) begin
                r[i] = ~w[i];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // reset reaches the link at once but leaves it on scl falls; scl may
    // stand still during reset, so a plain two-flop copy would miss it
    always_ff @(negedge scl or posedge rst_req_reg) begin
        if (rst_req_reg) begin
            rr_meta_reg <= 1'h1;
            rr_sync_reg <= 1'h1;
        end else begin
            rr_meta_reg <= 1'h0;
            rr_sync_reg <= rr_meta_reg;
        end
    end

    // pin synchronisers into the scl domain
    always_ff @(negedge scl) begin
        bz_meta_reg  <= busy_reg;
        bz_sync_reg  <= bz_meta_reg;
        pin_meta_reg <= {write_protect, chip_select_strap_bit2,
                         chip_select_strap_bit1, chip_select_strap_bit0};
        pin_sync_reg <= pin_meta_reg;
    end

    assign link_rst = rr_sync_reg;

    // data is taken on the rising edge
    always_ff @(posedge scl) begin
        sda_pos_reg <= sda_in;
    end

    // sda high at the rise but low at the fall means it dropped while
    // scl was high; a legal data bit never does that. after a stop scl
    // stays high with no rise, so the stop flag stands in for that level
    assign start_det = (sda_pos_reg | stop_flag_reg) &
                       ~sda_in;
    assign rx_byte   = {sh_reg[6:0], sda_pos_reg};
    assign byte_end  = (cnt_reg == `BIT_LAST);
    assign ack_end   = (cnt_reg == `BIT_ACK);
    assign addr_hit  = (rx_byte[7:4] == `DEV_PREFIX) &&
                       (rx_byte[3:1] == pin_sync_reg[2:0]) &&
                       !bz_sync_reg;
    assign wr_accept = (lstate_reg == L_WR) && byte_end && !wp_blk_reg;

    // stop: sda rising with scl high; no scl edge follows a stop, so it
    // is caught on sda itself and cleared by the next start
    always_ff @(posedge sda_in or posedge start_mark_reg
                or posedge rst_req_reg) begin
        if (start_mark_reg || rst_req_reg) begin
            stop_flag_reg <= 1'h0;
        end else if (scl) begin
            stop_flag_reg <= 1'h1;
        end
    end

    always_ff @(negedge scl) begin
        if (link_rst) begin
            start_mark_reg <= 1'h0;
        end else begin
            start_mark_reg <= start_det;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bit counter and receive shifter: bits 0..7 then the ack slot
    always_ff @(negedge scl) begin
        if (link_rst || start_det) begin
            cnt_reg <= 4'h0;
            sh_reg  <= 8'h00;
        end else begin
            sh_reg  <= rx_byte;
            cnt_reg <= ack_end ? 4'h0 : cnt_reg + 4'h1;
        end
    end

    // read data through ecc correction at the counter address
    always_comb begin
        rd_group = ptr_reg[14:2];
        rd_word  = {mem[{rd_group, 2'h3}], mem[{rd_group, 2'h2}],
                    mem[{rd_group, 2'h1}], mem[{rd_group, 2'h0}]};
        rd_word  = hfix(rd_word, ecc[rd_group]);
        rd_data  = rd_word[{ptr_reg[1:0], 3'h0} +: 8];
    end

    ////////////////////////////////////////////////////////////////////
    // link state machine; sda only ever pulled low, changed on the fall
    always_ff @(negedge scl) begin
        if (link_rst) begin
            lstate_reg <= L_IDLE;
            oe_reg     <= 1'h0;
            rw_reg     <= 1'h0;
            wp_blk_reg <= 1'h0;
            tx_reg     <= 8'h00;
            ptr_reg    <= '0;
        end else if (start_det) begin
            lstate_reg <= L_DEV;
            oe_reg     <= 1'h0;
        end else begin
            unique case (lstate_reg)
                L_IDLE: begin
                    oe_reg <= 1'h0;
                end
                L_DEV: begin
                    if (byte_end) begin
                        if (addr_hit) begin
                            oe_reg <= 1'h1;
                            rw_reg <= rx_byte[0];
                        end else begin
                            lstate_reg <= L_IDLE;
                        end
                    end else if (ack_end) begin
                        if (rw_reg) begin
                            tx_reg     <= rd_data;
                            oe_reg     <= ~rd_data[7];
                            ptr_reg    <= ptr_reg + 15'h0001;
                            lstate_reg <= L_RD;
                        end else begin
                            oe_reg     <= 1'h0;
                            lstate_reg <= L_AHI;
                        end
                    end
                end
                L_AHI: begin
                    if (byte_end) begin
                        ptr_reg[14:8] <= rx_byte[6:0];
                        oe_reg        <= 1'h1;
                    end else if (ack_end) begin
                        oe_reg     <= 1'h0;
                        lstate_reg <= L_ALO;
                    end
                end
                L_ALO: begin
                    if (byte_end) begin
                        ptr_reg[7:0] <= rx_byte;
                        oe_reg       <= 1'h1;
                    end else if (ack_end) begin
                        oe_reg     <= 1'h0;
                        wp_blk_reg <= pin_sync_reg[3];
                        lstate_reg <= L_WR;
                    end
                end
                L_WR: begin
                    if (byte_end) begin
                        if (wp_blk_reg) begin
                            lstate_reg <= L_IDLE;
                        end else begin
                            oe_reg       <= 1'h1;
                            ptr_reg[5:0] <= ptr_reg[5:0] + 6'h01;
                        end
                    end else if (ack_end) begin
                        oe_reg <= 1'h0;
                    end
                end
                L_RD: begin
                    if (cnt_reg < `BIT_LAST) begin
                        tx_reg <= {tx_reg[6:0], 1'h0};
                        oe_reg <= ~tx_reg[6];
                    end else if (byte_end) begin
                        oe_reg <= 1'h0;
                    end else if (!sda_pos_reg) begin
                        tx_reg  <= rd_data;
                        oe_reg  <= ~rd_data[7];
                        ptr_reg <= ptr_reg + 15'h0001;
                    end else begin
                        lstate_reg <= L_IDLE;
                    end
                end
            endcase
        end
    end

    // page buffer; a write counts only once a whole data byte is in
    always_ff @(negedge scl) begin
        if (link_rst) begin
            buf_mask_reg <= 64'h0;
            wr_pend_reg  <= 1'h0;
        end else if (start_det) begin
            wr_pend_reg <= 1'h0;
        end else if (lstate_reg == L_ALO && byte_end) begin
            buf_mask_reg <= 64'h0;
        end else if (wr_accept) begin
            page_buf[ptr_reg[5:0]]     <= rx_byte;
            buf_mask_reg[ptr_reg[5:0]] <= 1'h1;
            wr_pend_reg                <= 1'h1;
        end
    end

    assign sda_out = 1'h0;
    assign sda_oe  = oe_reg & ~rst_req_reg;

    ////////////////////////////////////////////////////////////////////
    // core domain: stop and pending-write crossings
    always_ff @(posedge clk) begin
        rst_req_reg   <= ~rstn;
        stop_meta_reg <= stop_flag_reg;
        stop_sync_reg <= stop_meta_reg;
        stop_prev_reg <= stop_sync_reg;
        wrp_meta_reg  <= wr_pend_reg;
        wrp_sync_reg  <= wrp_meta_reg;
    end

    assign stop_rise = stop_sync_reg & ~stop_prev_reg;

    // programming cycle; buffer and page pointer are quiet while busy
    // because the link nacks every address until busy drops
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cstate_reg <= C_STANDBY;
            wait_reg   <= 17'h00000;
            idx_reg    <= 6'h00;
        end else begin
            unique case (cstate_reg)
                C_STANDBY: begin
                    if (stop_rise && wrp_sync_reg) begin
                        cstate_reg <= C_PROG;
                        wait_reg   <= 17'h00000;
                    end
                end
                C_PROG: begin
                    if (wait_reg == 17'(WR_CYCLES - 1)) begin
                        cstate_reg <= C_COMMIT;
                        idx_reg    <= 6'h00;
                    end else begin
                        wait_reg <= wait_reg + 17'h00001;
                    end
                end
                C_COMMIT: begin
                    if (idx_reg == `PAGE_LAST) begin
                        cstate_reg <= C_STANDBY;
                    end
                    idx_reg <= idx_reg + 6'h01;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy_reg <= 1'h0;
        end else begin
            busy_reg <= (cstate_reg != C_STANDBY);
        end
    end

    assign write_busy = busy_reg;

    // one byte per cycle; its whole group gets fresh check bits
    always_comb begin
        wr_group = {ptr_reg[14:6], idx_reg[5:2]};
        new_word = {mem[{wr_group, 2'h3}], mem[{wr_group, 2'h2}],
                    mem[{wr_group, 2'h1}], mem[{wr_group, 2'h0}]};
        new_word[{idx_reg[1:0], 3'h0} +: 8] = page_buf[idx_reg];
    end

    always_ff @(posedge clk) begin
        if (cstate_reg == C_COMMIT && buf_mask_reg[idx_reg]) begin
            mem[{ptr_reg[14:6], idx_reg}] <= page_buf[idx_reg];
            ecc[wr_group] <= hcode(new_word);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_addr_ack;
        @(negedge scl) disable iff (link_rst)
        (lstate_reg == L_DEV && byte_end && !start_det && addr_hit)
            |=> oe_reg;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("matching address not acked");

    property p_busy_nack;
        @(negedge scl) disable iff (link_rst)
        (lstate_reg == L_DEV && byte_end && !start_det && bz_sync_reg)
            |=> !oe_reg && lstate_reg == L_IDLE;
    endproperty
    a_busy_nack: assert property (p_busy_nack)
        else $error("address acked while programming");

    property p_wp_reject;
        @(negedge scl) disable iff (link_rst)
        (lstate_reg == L_WR && byte_end && !start_det && wp_blk_reg)
            |=> !oe_reg && lstate_reg == L_IDLE && !$changed(buf_mask_reg);
    endproperty
    a_wp_reject: assert property (p_wp_reject)
        else $error("protected write byte was acked");

    property p_page_wrap;
        @(negedge scl) disable iff (link_rst)
        (wr_accept && !start_det) |=>
            ptr_reg[14:6] == $past(ptr_reg[14:6]) &&
            ptr_reg[5:0] == $past(ptr_reg[5:0]) + 6'h01;
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("write pointer left its page");

    property p_read_step;
        @(negedge scl) disable iff (link_rst)
        (lstate_reg == L_RD && ack_end && !sda_pos_reg && !start_det)
            |=> ptr_reg == $past(ptr_reg) + 15'h0001 && oe_reg == ~tx_reg[7];
    endproperty
    a_read_step: assert property (p_read_step)
        else $error("sequential read did not advance");

    property p_read_release;
        @(negedge scl) disable iff (link_rst)
        (lstate_reg == L_RD && byte_end && !start_det) |=> !oe_reg;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("sda held in read ack slot");

    property p_prog_start;
        @(posedge clk) disable iff (!rstn)
        (cstate_reg == C_STANDBY && stop_rise && wrp_sync_reg)
            |=> cstate_reg == C_PROG ##1 busy_reg;
    endproperty
    a_prog_start: assert property (p_prog_start)
        else $error("write stop did not start programming");

    property p_no_commit;
        @(posedge clk) disable iff (!rstn)
        (cstate_reg == C_STANDBY && !wrp_sync_reg) |=> cstate_reg == C_STANDBY;
    endproperty
    a_no_commit: assert property (p_no_commit)
        else $error("programming without a complete byte");

    property p_commit_end;
        @(posedge clk) disable iff (!rstn)
        (cstate_reg == C_COMMIT && idx_reg == `PAGE_LAST)
            |=> cstate_reg == C_STANDBY ##1 !busy_reg;
    endproperty
    a_commit_end: assert property (p_commit_end)
        else $error("commit did not end after the page");

    property p_reset_idle;
        @(posedge clk) !rstn |=> cstate_reg == C_STANDBY ##1 !busy_reg;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("reset did not return to standby");

    c_read_ack: cover property (@(negedge scl) disable iff (link_rst)
        lstate_reg == L_DEV && ack_end && rw_reg);
    c_write_byte: cover property (@(negedge scl) disable iff (link_rst)
        wr_accept);
    c_wp_block: cover property (@(negedge scl) disable iff (link_rst)
        lstate_reg == L_WR && byte_end && wp_blk_reg);
    c_commit: cover property (@(posedge clk) disable iff (!rstn)
        cstate_reg == C_COMMIT);

endmodule

`default_nettype wire

// >>> eeprom_map.svh
// constants for the serial eeprom slave: sizes, codes and timing
// assumes a core clock of 25 MHz and the bus clock as a separate domain
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

`define DEV_PREFIX      4'hA
`define MEM_BYTES       32768
`define ECC_GROUPS      8192
`define PAGE_LAST       6'h3F
`define ERASED_BYTE     8'hFF
`define ERASED_WORD     32'hFFFFFFFF
`define ERASED_ECC      6'h18
`define BIT_LAST        4'h7
`define BIT_ACK         4'h8
`define T_WR_NS         5000000
`define CLK_PERIOD_NS   40

`endif

// >>> eeprom_pkg.sv
// types shared by the serial eeprom slave
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package eeprom_pkg;

    typedef enum logic [2:0] {
        L_IDLE,
        L_DEV,
        L_AHI,
        L_ALO,
        L_WR,
        L_RD
    } link_state_e;

    typedef enum logic [1:0] {
        C_STANDBY,
        C_PROG,
        C_COMMIT
    } core_state_e;

    typedef logic [14:0] mem_addr_t;

endpackage

`default_nettype wire

// >>> i2c_master_model.sv
// behavioural two-wire bus master: makes scl, start/stop and bytes
// assumes the bench resolves sda from both pull-downs and a pull-up
`default_nettype none

module i2c_master_model (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;

    // scl stands high between frames; sda released means pulled up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // sda only moves while scl is low, except in start and stop
    task automatic pulse(output logic s);
        #20 scl = 1'b1;
        #20 s = sda;
        #20 scl = 1'b0;
        #20;
    endtask

    task automatic start();
        sda_low = 1'b0;
        #20 scl = 1'b1;
        #20 sda_low = 1'b1;
        #20 scl = 1'b0;
        #20;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #20 scl = 1'b1;
        #20 sda_low = 1'b0;
        #20;
    endtask

    task automatic idle(input int n);
        logic s;
        for (int i = 0; i < n; i++) pulse(s);
    endtask

    // fewer than 8 bits leaves a cut byte, with no ack pulse
    task automatic send(input logic [7:0] b, input int n, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 0; i < n; i++) begin
            sda_low = !b[7-i];
            pulse(s);
        end
        if (n == 8) begin
            sda_low = 1'b0;
            pulse(s);
            ack = !s;
        end
    endtask

    task automatic recv(input logic nack, output logic [7:0] b);
        logic s;
        sda_low = 1'b0;
        for (int i = 0; i < 8; i++) begin
            pulse(s);
            b = {b[6:0], s};
        end
        sda_low = !nack;
        pulse(s);
    endtask
endmodule

`default_nettype wire

// >>> eeprom_slave_tb_top.sv
// self-checking bench for the serial eeprom slave
// assumes i2c_master_model on the link; scl period 80 ns, clk 40 ns
`default_nettype none

module eeprom_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [6:0] DEV = 7'h55;
    logic       clk, rstn, scl, sda_low, sda_out, sda_oe, wp, busy;
    logic [2:0] strap;
    logic [7:0] q[$];
    int         fail_count, compares;
    wire logic  sda = !(sda_low | (sda_oe & !sda_out));

    eeprom_slave #(.WR_CYCLES(20)) dut_u (
        .clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_strap_bit0(strap[0]),
        .chip_select_strap_bit1(strap[1]),
        .chip_select_strap_bit2(strap[2]),
        .write_protect(wp), .write_busy(busy)
    );
    i2c_master_model m_u (.scl(scl), .sda_low(sda_low), .sda(sda));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic adr(logic [15:0] a);
        logic k;
        m_u.start();
        m_u.send({DEV, 1'b0}, 8, k);
        chk(k, 1);
        m_u.send(a[15:8], 8, k);
        chk(k, 1);
        m_u.send(a[7:0], 8, k);
        chk(k, 1);
    endtask

    // selective read when sel is set, else immediate read
    task automatic rd(bit sel, logic [15:0] a, int n);
        logic k;
        logic [7:0] b;
        q = {};
        if (sel) adr(a);
        m_u.start();
        m_u.send({DEV, 1'b1}, 8, k);
        chk(k, 1);
        for (int i = 0; i < n; i++) begin
            m_u.recv(i == n - 1, b);
            q.push_back(b);
        end
        m_u.stop();
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d[$], logic ok);
        logic k;
        adr(a);
        foreach (d[i]) begin
            m_u.send(d[i], 8, k);
            chk(k, ok);
        end
        m_u.stop();
    endtask

    // busy must rise, refuse a poll, then clear in bounded time
    task automatic prog();
        logic k;
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
        chk(busy, 1);
        m_u.start();
        m_u.send({DEV, 1'b0}, 8, k);
        m_u.stop();
        chk(k, 0);
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
        chk(busy, 0);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_refuse();
        logic k;
        logic [7:0] bad[2] = '{8'h5A, {4'hA, 3'b010, 1'b0}};
        foreach (bad[i]) begin
            m_u.start();
            m_u.send(bad[i], 8, k);
            m_u.stop();
            chk(k, 0);
        end
    endtask

    task automatic t_wrap();
        wr(16'hFFFF, '{8'h5A, 8'hC3}, 1'b1);
        prog();
        rd(1, 16'h7FFE, 1);
        chk(q[0], 8'hFF);
        rd(0, 16'h0000, 2);
        chk(q[0], 8'h5A);
        chk(q[1], 8'hFF);
        rd(1, 16'h7FC0, 1);
        chk(q[0], 8'hC3);
    endtask

    task automatic t_protect();
        @(posedge clk) wp <= 1'b1;
        wr(16'h0200, '{8'h11}, 1'b0);
        @(posedge clk) wp <= 1'b0;
        repeat (10) @(posedge clk);
        chk(busy, 0);
        rd(1, 16'h0200, 1);
        chk(q[0], 8'hFF);
    endtask

    // a cut data byte must not start programming
    task automatic t_partial();
        logic k;
        adr(16'h0300);
        m_u.send(8'h00, 4, k);
        m_u.stop();
        repeat (10) @(posedge clk);
        chk(busy, 0);
        rd(1, 16'h0300, 1);
        chk(q[0], 8'hFF);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        wp = 1'b0;
        strap = 3'b101;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        m_u.idle(4);
        chk(sda_oe, 0);
        t_refuse();
        t_wrap();
        t_protect();
        t_partial();
        end_sim();
    end

    initial begin
        #400us;
        fail_count++;
        end_sim();
    end
endmodule

`default_nettype wire
